// ---- logic/wdtb_pkg.sv ----
// Package of constants and types shared by the watchdog timer block
package wdtb_pkg;

  // Register addresses on the plain register port
  localparam logic [7:0] ADDR_UNITS = 8'h52;
  localparam logic [7:0] ADDR_PERIOD = 8'h53;
  localparam logic [7:0] ADDR_CONFIG = 8'h54;
  localparam logic [7:0] ADDR_CONTROL = 8'h55;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h5a;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h5b;

  // Field positions
  localparam int UNITS_SEL_BIT = 7;
  localparam int CFG_GAME_BIT = 0;
  localparam int CFG_KBD_BIT = 1;
  localparam int CFG_MOUSE_BIT = 2;
  localparam int CFG_MAP_LSB = 4;
  localparam int CFG_MAP_MSB = 7;
  localparam int CTL_STATUS_BIT = 0;
  localparam int CTL_FORCE_BIT = 2;
  localparam int CTL_KBC_EN_BIT = 3;
  localparam int EVT_TIMEOUT_BIT = 0;
  localparam int EVT_RESTART_BIT = 1;
  localparam int EVT_W = 2;

  // Writable bits and reset values
  localparam logic [7:0] UNITS_WMASK = 8'h80;
  localparam logic [7:0] CONFIG_WMASK = 8'hf7;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] PERIOD_OFF = 8'h00;
  localparam logic [7:0] COUNT_LAST = 8'h01;
  localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;
  localparam logic [15:0] ROUTE_NONE = 16'h0000;
  localparam logic [15:0] ROUTE_ONE = 16'h0001;
  localparam logic [3:0] MAP_DISABLE = 4'h0;
  localparam logic [3:0] MAP_INVALID = 4'h2;
  localparam logic EDGE_PREV_RST = 1'b1;

  // Timing: unit lengths and clock rate
  localparam int CLK_PERIOD_NS = 5;
  localparam int SECOND_NS = 1_000_000_000;
  localparam int SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;
  localparam int SECS_PER_MIN = 60;
  localparam int PRESC_W = 28;
  localparam int SECS_W = 6;

  // Watchdog counting state
  typedef enum logic [1:0] {WDTB_IDLE, WDTB_RUN, WDTB_FIRED} wdtb_state_t;

endpackage : wdtb_pkg

// ---- logic/wdtb_tick_if.sv ----
// Interface carrying the unit ticks between the tick divider and the watchdog core
`timescale 1ns/100ps
interface wdtb_tick_if;
  logic restart;
  logic sec_tick;
  logic min_tick;
  modport gen (input restart, output sec_tick, output min_tick);
  modport snk (output restart, input sec_tick, input min_tick);
endinterface : wdtb_tick_if

// ---- logic/wdtb_tick.sv ----
// Divider that makes one-second and one-minute ticks from the core clock
`timescale 1ns/100ps
module wdtb_tick #(
  parameter int SEC_CYCLES = wdtb_pkg::SEC_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  wdtb_tick_if.gen t
);
  logic [wdtb_pkg::PRESC_W-1:0] presc_q;
  logic [wdtb_pkg::SECS_W-1:0] secs_q;
  logic sec_end;
  logic min_end;

  assign sec_end = (presc_q == wdtb_pkg::PRESC_W'(SEC_CYCLES - 1));
  assign min_end = (secs_q == wdtb_pkg::SECS_W'(wdtb_pkg::SECS_PER_MIN - 1));

  // Restart zeroes both stages so a reload always gets a whole first unit
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      presc_q <= '0;
      secs_q <= '0;
      t.sec_tick <= 1'b0;
      t.min_tick <= 1'b0;
    end
    else if (t.restart)
    begin
      presc_q <= '0;
      secs_q <= '0;
      t.sec_tick <= 1'b0;
      t.min_tick <= 1'b0;
    end
    else
    begin
      presc_q <= sec_end ? '0 : presc_q + 1'b1;
      t.sec_tick <= sec_end;
      t.min_tick <= sec_end && min_end;
      if (sec_end)
        secs_q <= min_end ? '0 : secs_q + 1'b1;
    end
  end
endmodule : wdtb_tick

// ---- logic/wdtb_top.sv ----
// Watchdog timer core: registers, counter, forced timeouts and interrupt routing
// Notes on behaviour
// - Units bit 7 picks the tick: clear for minutes (default), set for seconds.
// - A timeout value of zero switches the watchdog off so it never expires.
// - A nonzero value N times out after N units, from 1 at 01h up to 255 at ffh.
// - With config bit 0 set, each game-port access restarts the count.
// - With config bit 1 set, each keyboard interrupt restarts the count.
// - With config bit 2 set, each mouse interrupt restarts the count.
// - Config bits 7:4 route the timeout: 0 off, 2 invalid, else that IRQ number.
// - Control bit 0 is a read/write status that reads 1 after a timeout.
// - Writing 1 to control bit 2 forces a timeout; the bit self-clears and reads 0.
// - With control bit 3 set, a rising edge of the kbc port bit forces a timeout.
// - Control clears on power-on resets; PCI reset clears all but the status bit.
// - Units bits 6:0 are reserved and read as zero.
// - The kbc port bit goes through a self-clearing edge detector ORed with force.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
module wdtb_top #(
  parameter int SEC_CYCLES = wdtb_pkg::SEC_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic pci_rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata_q,
  input wire logic game_port_access,
  input wire logic kbd_irq,
  input wire logic mouse_irq,
  input wire logic kbc_port_out_bit,
  output logic [15:0] timeout_irq_q,
  output logic irq_q
);

  // Map code to one-hot IRQ line; 0 and the invalid code drive nothing
  function automatic logic [15:0] wdtb_route(input logic [3:0] code);
    logic [15:0] line;
    line = wdtb_pkg::ROUTE_NONE;
    if (code != wdtb_pkg::MAP_DISABLE && code != wdtb_pkg::MAP_INVALID)
      line = wdtb_pkg::ROUTE_ONE << code;
    return line;
  endfunction : wdtb_route

  logic [7:0] units_q;
  logic [7:0] period_q;
  logic [7:0] cfg_q;
  logic [7:0] count_q;
  logic status_q;
  logic force_q;
  logic kbc_en_q;
  logic kbc_prev_q;
  logic kbc_pulse_q;
  logic kbd_prev_q;
  logic mouse_prev_q;
  logic [wdtb_pkg::EVT_W-1:0] evt_q;
  logic [wdtb_pkg::EVT_W-1:0] mask_q;
  logic [wdtb_pkg::EVT_W-1:0] evt_set;
  logic [wdtb_pkg::EVT_W-1:0] evt_clr;
  wdtb_pkg::wdtb_state_t state_q;
  logic wr_units;
  logic wr_period;
  logic wr_cfg;
  logic wr_ctrl;
  logic wr_evt;
  logic wr_mask;
  logic activity_w;
  logic restart_w;
  logic load_w;
  logic unit_tick_w;
  logic expire_w;
  logic timeout_w;
  logic [7:0] rd_mux;

  wdtb_tick_if tick_bus ();

  wdtb_tick #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_tick (
    .clock(clock),
    .rst(rst),
    .t(tick_bus.gen)
  );

  // Write strobes per register
  assign wr_units = wr && (addr == wdtb_pkg::ADDR_UNITS);
  assign wr_period = wr && (addr == wdtb_pkg::ADDR_PERIOD);
  assign wr_cfg = wr && (addr == wdtb_pkg::ADDR_CONFIG);
  assign wr_ctrl = wr && (addr == wdtb_pkg::ADDR_CONTROL);
  assign wr_evt = wr && (addr == wdtb_pkg::ADDR_EVT_STATUS);
  assign wr_mask = wr && (addr == wdtb_pkg::ADDR_EVT_MASK);

  // Activity sources; interrupts count once per rising edge, not per cycle high
  assign activity_w = (game_port_access && cfg_q[wdtb_pkg::CFG_GAME_BIT])
    || (kbd_irq && !kbd_prev_q && cfg_q[wdtb_pkg::CFG_KBD_BIT])
    || (mouse_irq && !mouse_prev_q && cfg_q[wdtb_pkg::CFG_MOUSE_BIT]);

  // A value write takes precedence over activity in the same cycle
  assign load_w = wr_period && (wdata != wdtb_pkg::PERIOD_OFF) && !pci_rst;
  assign restart_w = activity_w && (period_q != wdtb_pkg::PERIOD_OFF)
    && !wr_period && !pci_rst;
  assign tick_bus.restart = load_w || restart_w;

  assign unit_tick_w = units_q[wdtb_pkg::UNITS_SEL_BIT] ? tick_bus.sec_tick
    : tick_bus.min_tick;
  assign expire_w = (state_q == wdtb_pkg::WDTB_RUN) && unit_tick_w
    && (count_q == wdtb_pkg::COUNT_LAST) && !tick_bus.restart && !wr_period && !pci_rst;
  assign timeout_w = expire_w || force_q || kbc_pulse_q;

  // Counting state machine
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q <= wdtb_pkg::WDTB_IDLE;
      count_q <= wdtb_pkg::REG_RESET;
    end
    else if (pci_rst)
    begin
      state_q <= wdtb_pkg::WDTB_IDLE;
      count_q <= wdtb_pkg::REG_RESET;
    end
    else if (wr_period)
    begin
      // Zero stops the timer outright
      state_q <= load_w ? wdtb_pkg::WDTB_RUN : wdtb_pkg::WDTB_IDLE;
      count_q <= wdata;
    end
    else if (restart_w)
    begin
      state_q <= wdtb_pkg::WDTB_RUN;
      count_q <= period_q;
    end
    else
    begin
      case (state_q)
        wdtb_pkg::WDTB_RUN:
        begin
          if (force_q || kbc_pulse_q)
            state_q <= wdtb_pkg::WDTB_FIRED;
          else if (expire_w)
          begin
            state_q <= wdtb_pkg::WDTB_FIRED;
            count_q <= wdtb_pkg::REG_RESET;
          end
          else if (unit_tick_w)
            count_q <= count_q - 1'b1;
        end
        default:
        begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // Units, value and config: cleared by every reset source
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      units_q <= wdtb_pkg::REG_RESET;
      period_q <= wdtb_pkg::REG_RESET;
      cfg_q <= wdtb_pkg::REG_RESET;
    end
    else if (pci_rst)
    begin
      units_q <= wdtb_pkg::REG_RESET;
      period_q <= wdtb_pkg::REG_RESET;
      cfg_q <= wdtb_pkg::REG_RESET;
    end
    else
    begin
      if (wr_units)
        units_q <= wdata & wdtb_pkg::UNITS_WMASK;
      if (wr_period)
        period_q <= wdata;
      if (wr_cfg)
        cfg_q <= wdata & wdtb_pkg::CONFIG_WMASK;
    end
  end

  // Status bit survives PCI reset; a timeout wins over a clearing write
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      status_q <= 1'b0;
    else if (timeout_w)
      status_q <= 1'b1;
    else if (wr_ctrl && !pci_rst)
      status_q <= wdata[wdtb_pkg::CTL_STATUS_BIT];
  end

  // Other control bits clear on PCI reset
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      force_q <= 1'b0;
      kbc_en_q <= 1'b0;
    end
    else if (pci_rst)
    begin
      force_q <= 1'b0;
      kbc_en_q <= 1'b0;
    end
    else
    begin
      force_q <= wr_ctrl && wdata[wdtb_pkg::CTL_FORCE_BIT];
      if (wr_ctrl)
        kbc_en_q <= wdata[wdtb_pkg::CTL_KBC_EN_BIT];
    end
  end

  // Edge history starts high so a line already high at reset release never fires
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      kbc_prev_q <= wdtb_pkg::EDGE_PREV_RST;
      kbd_prev_q <= wdtb_pkg::EDGE_PREV_RST;
      mouse_prev_q <= wdtb_pkg::EDGE_PREV_RST;
      kbc_pulse_q <= 1'b0;
    end
    else
    begin
      kbc_prev_q <= kbc_port_out_bit;
      kbd_prev_q <= kbd_irq;
      mouse_prev_q <= mouse_irq;
      // One-cycle pulse even if the port bit stays high for ever
      kbc_pulse_q <= kbc_en_q && kbc_port_out_bit && !kbc_prev_q && !pci_rst;
    end
  end

  // Timeout routed to the selected IRQ line while status is set
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      timeout_irq_q <= wdtb_pkg::ROUTE_NONE;
    else if (status_q)
      timeout_irq_q <= wdtb_route(cfg_q[wdtb_pkg::CFG_MAP_MSB:wdtb_pkg::CFG_MAP_LSB]);
    else
      timeout_irq_q <= wdtb_pkg::ROUTE_NONE;
  end

  // Sticky event flags, write one to clear; a new event beats the clear
  assign evt_set = {restart_w, timeout_w};
  assign evt_clr = wr_evt ? wdata[wdtb_pkg::EVT_W-1:0] : wdtb_pkg::EVT_RESET;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      evt_q <= wdtb_pkg::EVT_RESET;
      mask_q <= wdtb_pkg::EVT_RESET;
      irq_q <= 1'b0;
    end
    else
    begin
      evt_q <= evt_set | (evt_q & ~evt_clr);
      if (wr_mask)
        mask_q <= wdata[wdtb_pkg::EVT_W-1:0];
      irq_q <= |(evt_q & mask_q);
    end
  end

  // Read decode; unmapped addresses read as zero
  always_comb
  begin
    rd_mux = wdtb_pkg::REG_RESET;
    if (addr == wdtb_pkg::ADDR_UNITS)
      rd_mux = units_q;
    else if (addr == wdtb_pkg::ADDR_PERIOD)
      rd_mux = period_q;
    else if (addr == wdtb_pkg::ADDR_CONFIG)
      rd_mux = cfg_q;
    else if (addr == wdtb_pkg::ADDR_CONTROL)
    begin
      rd_mux[wdtb_pkg::CTL_STATUS_BIT] = status_q;
      rd_mux[wdtb_pkg::CTL_KBC_EN_BIT] = kbc_en_q;
    end
    else if (addr == wdtb_pkg::ADDR_EVT_STATUS)
      rd_mux[wdtb_pkg::EVT_W-1:0] = evt_q;
    else if (addr == wdtb_pkg::ADDR_EVT_MASK)
      rd_mux[wdtb_pkg::EVT_W-1:0] = mask_q;
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rdata_q <= wdtb_pkg::REG_RESET;
    else
      rdata_q <= rd ? rd_mux : wdtb_pkg::REG_RESET;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_force_write;
    wr_ctrl && wdata[wdtb_pkg::CTL_FORCE_BIT] && !pci_rst;
  endsequence

  sequence s_force_done;
    force_q ##1 (!force_q && status_q);
  endsequence

  property p_force;
    s_force_write |=> s_force_done;
  endproperty
  a_force: assert property (p_force) else $error("forced timeout missing");

  property p_zero_off;
    expire_w |-> (period_q != wdtb_pkg::PERIOD_OFF);
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("expiry with zero value");

  property p_load;
    load_w |=> (state_q == wdtb_pkg::WDTB_RUN) && (count_q == $past(wdata));
  endproperty
  a_load: assert property (p_load) else $error("value write did not load");

  property p_units_rsvd;
    rd && (addr == wdtb_pkg::ADDR_UNITS) |=> (rdata_q[6:0] == 7'h00);
  endproperty
  a_units_rsvd: assert property (p_units_rsvd) else $error("reserved units bits");

  property p_game;
    game_port_access && cfg_q[wdtb_pkg::CFG_GAME_BIT] && (period_q != wdtb_pkg::PERIOD_OFF)
      && !wr_period && !pci_rst |=> (count_q == $past(period_q));
  endproperty
  a_game: assert property (p_game) else $error("game access did not restart");

  property p_kbc_force;
    kbc_en_q && kbc_port_out_bit && !kbc_prev_q && !pci_rst |=> kbc_pulse_q ##1 status_q;
  endproperty
  a_kbc_force: assert property (p_kbc_force) else $error("port edge did not force");

  property p_sticky;
    status_q && !(wr_ctrl && !wdata[wdtb_pkg::CTL_STATUS_BIT]) |=> status_q;
  endproperty
  a_sticky: assert property (p_sticky) else $error("status dropped");

  property p_route;
    status_q && (cfg_q[wdtb_pkg::CFG_MAP_MSB:wdtb_pkg::CFG_MAP_LSB] == 4'h3)
      |=> timeout_irq_q[3];
  endproperty
  a_route: assert property (p_route) else $error("IRQ3 route missing");

  property p_route_invalid;
    (cfg_q[wdtb_pkg::CFG_MAP_MSB:wdtb_pkg::CFG_MAP_LSB] == wdtb_pkg::MAP_INVALID)
      |=> (timeout_irq_q == wdtb_pkg::ROUTE_NONE);
  endproperty
  a_route_invalid: assert property (p_route_invalid) else $error("invalid code routed");

  property p_count_down;
    (state_q == wdtb_pkg::WDTB_RUN) && unit_tick_w && (count_q > wdtb_pkg::COUNT_LAST)
      && !tick_bus.restart && !wr_period && !pci_rst && !force_q && !kbc_pulse_q
      |=> (count_q == $past(count_q) - 8'h01);
  endproperty
  a_count_down: assert property (p_count_down) else $error("tick did not count");

  property p_pci;
    pci_rst && !timeout_w |=> (cfg_q == 8'h00) && (period_q == 8'h00) && !kbc_en_q
      && (status_q == $past(status_q));
  endproperty
  a_pci: assert property (p_pci) else $error("PCI reset effect wrong");

endmodule : wdtb_top

// ---- dv/wdtb_top_test.sv ----
// Self-checking testbench for the watchdog timer core
`timescale 1ns/100ps
module wdtb_top_test;
  localparam int SECC = 10;
  logic clock;
  logic rst;
  logic pci_rst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata_q;
  logic game_port_access;
  logic kbd_irq;
  logic mouse_irq;
  logic kbc_port_out_bit;
  logic [15:0] timeout_irq_q;
  logic irq_q;
  int failures;
  int compares;

  // Short second so a minute is only 600 cycles
  wdtb_top #(.SEC_CYCLES(SECC)) dut (
    .clock(clock),
    .rst(rst),
    .pci_rst(pci_rst),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata_q(rdata_q),
    .game_port_access(game_port_access),
    .kbd_irq(kbd_irq),
    .mouse_irq(mouse_irq),
    .kbc_port_out_bit(kbc_port_out_bit),
    .timeout_irq_q(timeout_irq_q),
    .irq_q(irq_q)
  );

  // 200 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic complete_run;
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_line(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_line

  // One-cycle write strobe beside address and data
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : bus_wr

  // Read strobe, then data valid only in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk_reg(rdata_q, exp);
  endtask : rd_chk

  // One-cycle high on an activity source; a rising edge for the interrupt inputs
  task automatic pulse_src(input int idx);
    @(posedge clock);
    case (idx)
      0: game_port_access <= 1'b1;
      1: kbd_irq <= 1'b1;
      default: mouse_irq <= 1'b1;
    endcase
    @(posedge clock);
    game_port_access <= 1'b0;
    kbd_irq <= 1'b0;
    mouse_irq <= 1'b0;
  endtask : pulse_src

  task automatic test_reset_map;
    rd_chk(wdtb_pkg::ADDR_UNITS, 8'h00);
    rd_chk(wdtb_pkg::ADDR_PERIOD, 8'h00);
    rd_chk(wdtb_pkg::ADDR_CONFIG, 8'h00);
    rd_chk(wdtb_pkg::ADDR_CONTROL, 8'h00);
    bus_wr(8'h60, 8'hff);
    rd_chk(8'h60, 8'h00);
    bus_wr(wdtb_pkg::ADDR_UNITS, 8'hff);
    rd_chk(wdtb_pkg::ADDR_UNITS, 8'h80);
    bus_wr(wdtb_pkg::ADDR_CONFIG, 8'hff);
    rd_chk(wdtb_pkg::ADDR_CONFIG, 8'hf7);
  endtask : test_reset_map

  task automatic test_seconds;
    bus_wr(wdtb_pkg::ADDR_UNITS, 8'h80);
    bus_wr(wdtb_pkg::ADDR_CONFIG, 8'h30);
    bus_wr(wdtb_pkg::ADDR_PERIOD, 8'h02);
    repeat (15) @(posedge clock);
    rd_chk(wdtb_pkg::ADDR_CONTROL, 8'h00);
    repeat (6) @(posedge clock);
    rd_chk(wdtb_pkg::ADDR_CONTROL, 8'h01);
    chk_line(timeout_irq_q, 16'h0008);
    bus_wr(wdtb_pkg::ADDR_CONTROL, 8'h00);
    repeat (2) @(posedge clock);
    chk_line(timeout_irq_q, 16'h0000);
    // Zero written while counting must stop it for well over two seconds
    bus_wr(wdtb_pkg::ADDR_PERIOD, 8'h02);
    repeat (5) @(posedge clock);
    bus_wr(wdtb_pkg::ADDR_PERIOD, 8'h00);
    repeat (40) @(posedge clock);
    rd_chk(wdtb_pkg::ADDR_CONTROL, 8'h00);
  endtask : test_seconds

  // Pulses every 12 cycles hold off a 20-cycle timeout only when enabled
  task automatic test_restart(input int idx, input logic en);
    bus_wr(wdtb_pkg::ADDR_CONFIG, en ? (8'h01 << idx) : 8'h00);
    bus_wr(wdtb_pkg::ADDR_PERIOD, 8'h02);
    for (int i = 0; i < 4; i++)
    begin
      repeat (10) @(posedge clock);
      pulse_src(idx);
    end
    rd_chk(wdtb_pkg::ADDR_CONTROL, en ? 8'h00 : 8'h01);
    repeat (25) @(posedge clock);
    rd_chk(wdtb_pkg::ADDR_CONTROL, 8'h01);
    bus_wr(wdtb_pkg::ADDR_CONTROL, 8'h00);
  endtask : test_restart

  task automatic test_minutes;
    bus_wr(wdtb_pkg::ADDR_UNITS, 8'h00);
    bus_wr(wdtb_pkg::ADDR_PERIOD, 8'h01);
    repeat (60 * SECC - 10) @(posedge clock);
    rd_chk(wdtb_pkg::ADDR_CONTROL, 8'h00);
    repeat (15) @(posedge clock);
    rd_chk(wdtb_pkg::ADDR_CONTROL, 8'h01);
    bus_wr(wdtb_pkg::ADDR_CONTROL, 8'h00);
    bus_wr(wdtb_pkg::ADDR_PERIOD, 8'h00);
  endtask : test_minutes

  // Forced timeout through every routing code
  task automatic test_force_route;
    logic [15:0] exp;
    for (int c = 0; c < 16; c++)
    begin
      exp = (c == 0 || c == 2) ? 16'h0000 : (16'h0001 << c);
      bus_wr(wdtb_pkg::ADDR_CONFIG, 8'(c << 4));
      bus_wr(wdtb_pkg::ADDR_CONTROL, 8'h04);
      repeat (4) @(posedge clock);
      chk_line(timeout_irq_q, exp);
      rd_chk(wdtb_pkg::ADDR_CONTROL, 8'h01);
      bus_wr(wdtb_pkg::ADDR_CONTROL, 8'h00);
    end
    bus_wr(wdtb_pkg::ADDR_CONTROL, 8'h01);
    rd_chk(wdtb_pkg::ADDR_CONTROL, 8'h01);
    bus_wr(wdtb_pkg::ADDR_CONTROL, 8'h00);
  endtask : test_force_route

  // Port bit held high forces only once; disabled edges do nothing
  task automatic test_port_bit;
    bus_wr(wdtb_pkg::ADDR_CONTROL, 8'h08);
    kbc_port_out_bit <= 1'b1;
    repeat (4) @(posedge clock);
    rd_chk(wdtb_pkg::ADDR_CONTROL, 8'h09);
    bus_wr(wdtb_pkg::ADDR_CONTROL, 8'h08);
    repeat (5) @(posedge clock);
    rd_chk(wdtb_pkg::ADDR_CONTROL, 8'h08);
    @(posedge clock);
    kbc_port_out_bit <= 1'b0;
    bus_wr(wdtb_pkg::ADDR_CONTROL, 8'h00);
    kbc_port_out_bit <= 1'b1;
    repeat (5) @(posedge clock);
    rd_chk(wdtb_pkg::ADDR_CONTROL, 8'h00);
    @(posedge clock);
    kbc_port_out_bit <= 1'b0;
  endtask : test_port_bit

  task automatic test_pci_reset;
    bus_wr(wdtb_pkg::ADDR_UNITS, 8'h80);
    bus_wr(wdtb_pkg::ADDR_PERIOD, 8'h05);
    bus_wr(wdtb_pkg::ADDR_CONFIG, 8'hf7);
    bus_wr(wdtb_pkg::ADDR_CONTROL, 8'h09);
    @(posedge clock);
    pci_rst <= 1'b1;
    @(posedge clock);
    pci_rst <= 1'b0;
    rd_chk(wdtb_pkg::ADDR_UNITS, 8'h00);
    rd_chk(wdtb_pkg::ADDR_PERIOD, 8'h00);
    rd_chk(wdtb_pkg::ADDR_CONFIG, 8'h00);
    rd_chk(wdtb_pkg::ADDR_CONTROL, 8'h01);
    bus_wr(wdtb_pkg::ADDR_CONTROL, 8'h00);
  endtask : test_pci_reset

  // Event status, mask and the level interrupt
  task automatic test_events;
    bus_wr(wdtb_pkg::ADDR_EVT_STATUS, 8'h03);
    bus_wr(wdtb_pkg::ADDR_EVT_MASK, 8'h01);
    rd_chk(wdtb_pkg::ADDR_EVT_MASK, 8'h01);
    bus_wr(wdtb_pkg::ADDR_CONTROL, 8'h04);
    repeat (4) @(posedge clock);
    chk_line(16'(irq_q), 16'h0001);
    rd_chk(wdtb_pkg::ADDR_EVT_STATUS, 8'h01);
    bus_wr(wdtb_pkg::ADDR_EVT_MASK, 8'h00);
    repeat (2) @(posedge clock);
    chk_line(16'(irq_q), 16'h0000);
    bus_wr(wdtb_pkg::ADDR_EVT_MASK, 8'h01);
    repeat (2) @(posedge clock);
    chk_line(16'(irq_q), 16'h0001);
    bus_wr(wdtb_pkg::ADDR_EVT_STATUS, 8'h01);
    repeat (2) @(posedge clock);
    chk_line(16'(irq_q), 16'h0000);
    bus_wr(wdtb_pkg::ADDR_CONTROL, 8'h00);
    bus_wr(wdtb_pkg::ADDR_CONFIG, 8'h01);
    bus_wr(wdtb_pkg::ADDR_PERIOD, 8'h05);
    pulse_src(0);
    rd_chk(wdtb_pkg::ADDR_EVT_STATUS, 8'h02);
  endtask : test_events

  // Hang guard well beyond the expected run length
  initial
  begin
    #100000;
    failures++;
    complete_run();
  end

  initial
  begin
    failures = 0;
    compares = 0;
    rst = 1'b1;
    pci_rst = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    game_port_access = 1'b0;
    kbd_irq = 1'b0;
    mouse_irq = 1'b0;
    kbc_port_out_bit = 1'b0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    test_reset_map();
    test_seconds();
    for (int s = 0; s < 3; s++)
    begin
      test_restart(s, 1'b1);
      test_restart(s, 1'b0);
    end
    test_minutes();
    test_force_route();
    test_port_bit();
    test_pci_reset();
    test_events();
    complete_run();
  end
endmodule : wdtb_top_test
